// ===== hw/dxc_ctrl.sv
`timescale 1ns/10ps
module dxc_ctrl
  import dxc_pkg::*;
#(
  parameter int SEC_WIDTH = dxc_pkg::SEC_W,
  parameter int SECTIONS = dxc_pkg::NUM_SEC,
  parameter int DEPTH = dxc_pkg::FIFO_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [SECTIONS-1:0] i_mode_valid,
  input wire dxc_pkg::dxc_mode_t i_mode [SECTIONS],
  output logic [SECTIONS-1:0] o_mode_ready,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  input wire logic [SEC_WIDTH*SECTIONS-1:0] i_tx_data,
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  output logic [SEC_WIDTH*SECTIONS-1:0] o_rx_data,
  output logic [SECTIONS-1:0] o_oe_n,
  output logic [SECTIONS-1:0] o_dir,
  output logic [SEC_WIDTH*SECTIONS-1:0] o_a_out,
  output logic [SEC_WIDTH*SECTIONS-1:0] o_a_oe,
  input wire logic [SEC_WIDTH*SECTIONS-1:0] i_a_in,
  output logic [SECTIONS-1:0] o_a2b_sec
);
  import dxc_pkg::*;
  localparam int W = SEC_WIDTH * SECTIONS;

  logic [SECTIONS-1:0] oe_n_r;
  logic [SECTIONS-1:0] oe_n_nxt;
  logic [SECTIONS-1:0] dir_r;
  logic [SECTIONS-1:0] dir_nxt;
  logic [SECTIONS-1:0] busy_r;
  logic [SECTIONS-1:0] busy_nxt;
  logic [SECTIONS-1:0] tgt_on;
  logic [SECTIONS-1:0] tgt_dir;
  logic [3:0] turn_r [SECTIONS];
  logic [3:0] turn_nxt [SECTIONS];
  logic [W-1:0] a_out_r;
  logic [W-1:0] a_out_nxt;
  logic [W-1:0] a_oe_r;
  logic [W-1:0] a_oe_nxt;
  logic [W-1:0] s1_r;
  logic [W-1:0] s1_nxt;
  logic [W-1:0] s2_r;
  logic [W-1:0] s2_nxt;
  logic [W-1:0] s3_r;
  logic [W-1:0] s3_nxt;
  logic [W-1:0] rx_r;
  logic [W-1:0] rx_nxt;
  logic fifo_valid, fifo_ready;
  logic [W-1:0] fifo_data;

  // tx words wait here until the A-to-B sections can take them
  dxc_fifo #(.WIDTH(W), .DEPTH(DEPTH)) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_in_valid(i_tx_valid),
    .o_in_ready(o_tx_ready),
    .i_in_data(i_tx_data),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_ready),
    .o_out_data(fifo_data)
  );

  // a word drains only when some section drives B and none is mid-turn
  assign fifo_ready = (|o_a2b_sec) && (busy_r == '0);

  generate
    for (genvar s = 0; s < SECTIONS; s++) begin : g_sec
      localparam int LO = s * SEC_WIDTH;
      assign o_mode_ready[s] = !busy_r[s];
      assign o_a2b_sec[s] = !oe_n_r[s] && dir_r[s] && !busy_r[s];

      // decode the wanted mode; code 11 falls back to isolation
      always_comb begin
        tgt_on[s] = 1'b0;
        tgt_dir[s] = 1'b0;
        unique case (i_mode[s])
          DXC_A2B: begin
            tgt_on[s] = 1'b1;
            tgt_dir[s] = 1'b1;
          end
          DXC_B2A: begin
            tgt_on[s] = 1'b1;
            tgt_dir[s] = 1'b0;
          end
          default: begin
            tgt_on[s] = 1'b0;
          end
        endcase
      end

      // sequence: disable, wait turnaround, then set dir and enable in the same cycle
      always_comb begin
        oe_n_nxt[s] = oe_n_r[s];
        dir_nxt[s] = dir_r[s];
        busy_nxt[s] = busy_r[s];
        turn_nxt[s] = turn_r[s];
        a_oe_nxt[LO +: SEC_WIDTH] = a_oe_r[LO +: SEC_WIDTH];
        if (i_mode_valid[s] && !busy_r[s]) begin
          oe_n_nxt[s] = 1'b1;
          a_oe_nxt[LO +: SEC_WIDTH] = '0;
          busy_nxt[s] = 1'b1;
          turn_nxt[s] = TURN_CYC_W;
        end else if (busy_r[s]) begin
          if (turn_r[s] != '0) begin
            turn_nxt[s] = turn_r[s] - 4'h1;
          end else begin
            busy_nxt[s] = 1'b0;
            dir_nxt[s] = tgt_dir[s];
            oe_n_nxt[s] = !tgt_on[s];
            // we drive A only while the transceiver listens there
            a_oe_nxt[LO +: SEC_WIDTH] = {SEC_WIDTH{tgt_on[s] && tgt_dir[s]}};
          end
        end
      end

      always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
          oe_n_r[s] <= OE_N_RST[0];
          dir_r[s] <= DIR_RST[0];
          busy_r[s] <= 1'b0;
          turn_r[s] <= '0;
          a_oe_r[LO +: SEC_WIDTH] <= '0;
        end else begin
          oe_n_r[s] <= oe_n_nxt[s];
          dir_r[s] <= dir_nxt[s];
          busy_r[s] <= busy_nxt[s];
          turn_r[s] <= turn_nxt[s];
          a_oe_r[LO +: SEC_WIDTH] <= a_oe_nxt[LO +: SEC_WIDTH];
        end
      end

      // a popped word reaches the A pins one cycle after its pop
      always_comb begin
        a_out_nxt[LO +: SEC_WIDTH] = a_out_r[LO +: SEC_WIDTH];
        if (fifo_valid && fifo_ready && o_a2b_sec[s]) begin
          a_out_nxt[LO +: SEC_WIDTH] = fifo_data[LO +: SEC_WIDTH];
        end
      end

      always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
          a_out_r[LO +: SEC_WIDTH] <= '0;
        end else begin
          a_out_r[LO +: SEC_WIDTH] <= a_out_nxt[LO +: SEC_WIDTH];
        end
      end

      // a byte counts only once two late stages agree
      always_comb begin
        rx_nxt[LO +: SEC_WIDTH] = rx_r[LO +: SEC_WIDTH];
        if (s3_r[LO +: SEC_WIDTH] == s2_r[LO +: SEC_WIDTH]) begin
          rx_nxt[LO +: SEC_WIDTH] = s3_r[LO +: SEC_WIDTH];
        end
      end

      always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
          rx_r[LO +: SEC_WIDTH] <= '0;
        end else begin
          rx_r[LO +: SEC_WIDTH] <= rx_nxt[LO +: SEC_WIDTH];
        end
      end
    end
  endgenerate

  // pin synchroniser; only the second stage reads the first
  always_comb begin
    s1_nxt = i_a_in;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
    end
  end

  assign o_oe_n = oe_n_r;
  assign o_dir = dir_r;
  assign o_a_out = a_out_r;
  assign o_a_oe = a_oe_r;
  assign o_rx_data = rx_r;
  // receive path runs always; sink may ignore it in A-to-B mode
  assign o_rx_valid = 1'b1;
  logic unused_rx_ready;
  assign unused_rx_ready = i_rx_ready;
endmodule : dxc_ctrl

// ===== hw/dxc_fifo.sv
`timescale 1ns/10ps
module dxc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign o_in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_r != '0);
  assign o_out_data = mem_r[rp_r];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      wp_nxt = (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
    end
    if (pop) begin
      rp_nxt = (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage needs no reset; valid gates every read
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_r[wp_r] <= i_in_data;
    end
  end
endmodule : dxc_fifo

// ===== hw/dxc_pkg.sv
package dxc_pkg;
  localparam int SEC_W = 8;
  localparam int NUM_SEC = 2;
  localparam int FIFO_DEPTH = 4;
  localparam logic [1:0] OE_N_RST = 2'h3;
  localparam logic [1:0] DIR_RST = 2'h0;
  localparam real CLK_NS = 50.0;
  localparam real TURN_NS = 50.0;
  localparam int TURN_CYC = (int'(TURN_NS / CLK_NS) < 1) ? 1 : int'(TURN_NS / CLK_NS);
  localparam logic [3:0] TURN_CYC_W = TURN_CYC[3:0];
  typedef enum logic [1:0] {
    DXC_ISOL = 2'b00,
    DXC_A2B = 2'b01,
    DXC_B2A = 2'b10
  } dxc_mode_t;
endpackage : dxc_pkg

// ===== tb/dxc_ctrl_properties.sv
`timescale 1ns/10ps
module dxc_ctrl_properties
  import dxc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [1:0] i_mode_valid,
  input wire dxc_pkg::dxc_mode_t i_mode [2],
  input wire logic [1:0] o_mode_ready,
  input wire logic [1:0] o_oe_n,
  input wire logic [1:0] o_dir,
  input wire logic [15:0] o_a_oe
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  wire logic [15:0] dev_a = {{8{~o_oe_n[1] & ~o_dir[1]}}, {8{~o_oe_n[0] & ~o_dir[0]}}};
  sequence s_take;
    i_mode_valid[0] && o_mode_ready[0] && i_mode[0] == DXC_A2B;
  endsequence
  property p_park; $fell(i_rst) |-> o_oe_n == 2'h3 && o_dir == 2'h0; endproperty
  a_park: assert property (p_park) else $error("not parked");
  property p_fight; (o_a_oe & dev_a) == 16'h0; endproperty
  a_fight: assert property (p_fight) else $error("A contention");
  property p_dir; ((o_dir ^ $past(o_dir)) & ~$past(o_oe_n)) == 2'h0; endproperty
  a_dir: assert property (p_dir) else $error("dir moved while on");
  property p_a2b; s_take |=> o_oe_n[0] ##[1:3] (!o_oe_n[0] && o_dir[0]); endproperty
  a_a2b: assert property (p_a2b) else $error("A2B late");
endmodule : dxc_ctrl_properties
bind dxc_ctrl dxc_ctrl_properties u_dxc_ctrl_properties (.i_ref_clk, .i_rst, .i_mode_valid,
  .i_mode, .o_mode_ready, .o_oe_n, .o_dir, .o_a_oe);

// ===== tb/dxc_xcvr_model.sv
`timescale 1ns/10ps
module dxc_xcvr_model (
  input wire logic [1:0] i_oe_n,
  input wire logic [1:0] i_dir,
  input wire logic [15:0] i_a,
  input wire logic [15:0] i_b,
  output logic [15:0] o_a,
  output logic [15:0] o_a_en,
  output logic [15:0] o_b,
  output logic [15:0] o_b_en
);
  // receivers never switch off
  assign o_a = i_b;
  assign o_b = i_a;
  assign o_a_en = {{8{~i_oe_n[1] & ~i_dir[1]}}, {8{~i_oe_n[0] & ~i_dir[0]}}};
  assign o_b_en = {{8{~i_oe_n[1] & i_dir[1]}}, {8{~i_oe_n[0] & i_dir[0]}}};
endmodule : dxc_xcvr_model

// ===== tb/testbench.sv
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %0t %h %h", $time, g, e); end end
module testbench;
  import dxc_pkg::*;
  logic i_ref_clk = 1'b0, i_rst = 1'b1, i_tx_valid = 1'b0, o_tx_ready, o_rx_valid;
  logic [1:0] i_mode_valid = 2'h0, o_mode_ready, o_oe_n, o_dir, o_a2b_sec;
  dxc_mode_t i_mode [2] = '{DXC_ISOL, DXC_ISOL};
  logic [15:0] i_tx_data = 16'h0, bv = 16'h0, lw, o_rx_data, o_a_out, o_a_oe, da, dae, db, dbe;
  logic [15:0] q [$];
  int seed = 98450, n_mismatch = 0, comparisons = 0, cyc = 0;
  // lines nobody drives sit on pull-ups
  wire logic [15:0] i_a_in = (o_a_oe & o_a_out) | (~o_a_oe & dae & da) | ~(o_a_oe | dae);
  wire logic [15:0] b_w = (dbe & db) | (~dbe & bv);
  always #25 i_ref_clk = ~i_ref_clk;
  dxc_ctrl u_dxc_ctrl (.i_ref_clk, .i_rst, .i_mode_valid, .i_mode, .o_mode_ready, .i_tx_valid,
    .o_tx_ready, .i_tx_data, .o_rx_valid, .i_rx_ready(1'b1), .o_rx_data, .o_oe_n, .o_dir,
    .o_a_out, .o_a_oe, .i_a_in, .o_a2b_sec);
  dxc_xcvr_model u_dxc_xcvr_model (.i_oe_n(o_oe_n), .i_dir(o_dir), .i_a(i_a_in), .i_b(b_w),
    .o_a(da), .o_a_en(dae), .o_b(db), .o_b_en(dbe));
  function automatic logic [15:0] mix(logic [15:0] lo, logic [15:0] hi);
    return {hi[15:8], lo[7:0]};
  endfunction : mix
  task tick;
    @(posedge i_ref_clk);
    #1;
  endtask : tick
  task set_mode(logic [1:0] sel, dxc_mode_t m);
    for (int s = 0; s < 2; s++) if (sel[s]) i_mode[s] = m;
    i_mode_valid = sel;
    while ((o_mode_ready & sel) !== sel) tick();
    tick();
    i_mode_valid = 2'h0;
    tick();
    while (o_mode_ready !== 2'h3) tick();
  endtask : set_mode
  task complete_run;
    if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    repeat (8) tick();
    i_rst = 1'b0;
    `CHK(o_oe_n, 2'h3)
    set_mode(2'h3, DXC_ISOL);
    `CHK(dae | dbe, 16'h0)
    // isolated sections never drain, so the fifth word is refused
    i_tx_valid = 1'b1;
    repeat (6) begin
      i_tx_data = $random(seed);
      if (o_tx_ready === 1'b1) q.push_back(i_tx_data);
      tick();
    end
    i_tx_valid = 1'b0;
    `CHK(q.size(), FIFO_DEPTH)
    lw = q[$];
    set_mode(2'h3, DXC_A2B);
    `CHK(o_a2b_sec, 2'h3)
    `CHK(o_dir, 2'h3)
    repeat (8) begin
      if (q.size() > 0 && b_w === q[0]) void'(q.pop_front());
      tick();
    end
    `CHK(q.size(), 0)
    set_mode(2'h1, DXC_B2A);
    `CHK(o_dir, 2'h2)
    `CHK(o_oe_n, 2'h0)
    repeat (3) begin
      bv = $random(seed);
      repeat (5) tick();
      `CHK(o_rx_data, mix(bv, lw))
      `CHK(o_rx_valid, 1'b1)
    end
    complete_run();
  end
endmodule : testbench
